// File: hdl/fco_override.sv
// critical-limit override, off-margin on/off control and apb register file
// assumes temperatures and automatic duties arrive synchronous to core_clk
`timescale 1ns/1ns
module fco_override
    import fco_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  temp_remote1,
    input  wire logic [7:0]  temp_local,
    input  wire logic [7:0]  temp_remote2,
    input  wire logic [7:0]  auto_duty_1,
    input  wire logic [7:0]  auto_duty_2,
    input  wire logic [7:0]  auto_duty_3,
    output logic      [7:0]  fan_drive_1,
    output logic      [7:0]  fan_drive_2,
    output logic      [7:0]  fan_drive_3,
    output logic             critical_temp_signal
);

    // saturate so a margin wider than the limit never wraps round to a high release point
    function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [3:0] b);
        sat_sub = (a > {4'h0, b}) ? (a - {4'h0, b}) : 8'h00;
    endfunction

    function automatic logic [7:0] cap(input logic [7:0] a, input logic [7:0] lim);
        cap = (a > lim) ? lim : a;
    endfunction

    logic [7:0] temp_a  [NCH];
    logic [7:0] auto_a  [NCH];
    logic [7:0] crit_q  [NCH];
    logic [3:0] margin_q[NCH];
    logic [7:0] start_q [NCH];
    logic [7:0] min_q   [NCH];
    logic [7:0] max_q   [NCH];
    logic [7:0] duty_q  [NCH];
    logic [7:0] duty_d  [NCH];
    logic [7:0] crit_off[NCH];
    logic [7:0] run_off [NCH];
    logic [2:0] floor_sel_q;
    logic [2:0] ovr_q;
    logic [2:0] ovr_d;
    logic [2:0] run_q;
    logic [2:0] run_d;
    logic       any_ovr_d;
    logic [7:0] idx;
    logic       acc;
    logic       wr;
    logic       hit;

    assign temp_a[0] = temp_remote1;
    assign temp_a[1] = temp_local;
    assign temp_a[2] = temp_remote2;
    assign auto_a[0] = auto_duty_1;
    assign auto_a[1] = auto_duty_2;
    assign auto_a[2] = auto_duty_3;

    // a frozen block must not complete transfers, so ready follows the enable
    assign pready = clk_en;
    assign idx    = paddr[9:2];
    assign acc    = psel && penable && pready;
    assign wr     = acc && pwrite;

    always_comb begin
        hit = 1'b1;
        unique case (idx)
            REG_FLOOR_SEL, REG_CRIT_R1, REG_CRIT_LOC, REG_CRIT_R2,
            REG_MARGIN_A, REG_MARGIN_B, REG_STATUS : hit = 1'b1;
            default : begin
                hit = (idx >= REG_START_R1) && (idx < REG_STATUS);
            end
        endcase
    end

    assign pslverr = acc && !hit;

    // limits and margins
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NCH; i++) begin
                crit_q[i]   <= CRIT_RST;
                margin_q[i] <= MARGIN_RST;
            end
        end else if (clk_en && wr) begin
            if (idx == REG_CRIT_R1) crit_q[0] <= pwdata[7:0];
            if (idx == REG_CRIT_LOC) crit_q[1] <= pwdata[7:0];
            if (idx == REG_CRIT_R2) crit_q[2] <= pwdata[7:0];
            if (idx == REG_MARGIN_A) begin
                margin_q[0] <= pwdata[MARGIN_HI_LSB +: 4];
                margin_q[1] <= pwdata[MARGIN_LO_LSB +: 4];
            end
            if (idx == REG_MARGIN_B) margin_q[2] <= pwdata[MARGIN_HI_LSB +: 4];
        end
    end

    // fan-start, floor and ceiling configuration
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            floor_sel_q <= FLOOR_SEL_RST;
            for (int i = 0; i < NCH; i++) begin
                start_q[i] <= START_RST;
                min_q[i]   <= MIN_RST;
                max_q[i]   <= MAX_RST;
            end
        end else if (clk_en && wr) begin
            if (idx == REG_FLOOR_SEL) floor_sel_q <= pwdata[FLOOR_SEL_LSB +: 3];
            for (int i = 0; i < NCH; i++) begin
                if (idx == REG_START_R1 + 8'(i)) start_q[i] <= pwdata[7:0];
                if (idx == REG_MIN_1 + 8'(i)) min_q[i] <= pwdata[7:0];
                if (idx == REG_MAX_1 + 8'(i)) max_q[i] <= pwdata[7:0];
            end
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (idx)
            REG_FLOOR_SEL : prdata[FLOOR_SEL_LSB +: 3] = floor_sel_q;
            REG_CRIT_R1   : prdata[7:0] = crit_q[0];
            REG_CRIT_LOC  : prdata[7:0] = crit_q[1];
            REG_CRIT_R2   : prdata[7:0] = crit_q[2];
            REG_MARGIN_A  : prdata[7:0] = {margin_q[0], margin_q[1]};
            REG_MARGIN_B  : prdata[MARGIN_HI_LSB +: 4] = margin_q[2];
            REG_STATUS    : begin
                prdata[STATUS_RUN_LSB +: 3] = run_q;
                prdata[2:0]                 = ovr_q;
            end
            default : begin
                for (int i = 0; i < NCH; i++) begin
                    if (idx == REG_START_R1 + 8'(i)) prdata[7:0] = start_q[i];
                    if (idx == REG_MIN_1 + 8'(i)) prdata[7:0] = min_q[i];
                    if (idx == REG_MAX_1 + 8'(i)) prdata[7:0] = max_q[i];
                end
            end
        endcase
    end

    // one margin per channel sets both release points; zero margin gives no gap
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            crit_off[i] = sat_sub(crit_q[i], margin_q[i]);
            run_off[i]  = sat_sub(start_q[i], margin_q[i]);
            ovr_d[i] = ovr_q[i];
            if (temp_a[i] > crit_q[i]) ovr_d[i] = 1'b1;
            else if (temp_a[i] < crit_off[i]) ovr_d[i] = 1'b0;
            run_d[i] = run_q[i];
            if (temp_a[i] > start_q[i]) run_d[i] = 1'b1;
            else if (temp_a[i] < run_off[i]) run_d[i] = 1'b0;
        end
    end

    assign any_ovr_d = |ovr_d;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ovr_q <= 3'h0;
            run_q <= 3'h0;
        end else if (clk_en) begin
            ovr_q <= ovr_d;
            run_q <= run_d;
        end
    end

    // output n follows channel n; the override sits above every setting
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (any_ovr_d) begin
                duty_d[i] = DUTY_FULL;
            end else if (floor_sel_q[i]) begin
                // always-running output ignores the margin entirely
                duty_d[i] = (temp_a[i] > start_q[i]) ? cap(auto_a[i], max_q[i]) : min_q[i];
            end else if (run_d[i]) begin
                duty_d[i] = cap(auto_a[i], max_q[i]);
            end else begin
                duty_d[i] = DUTY_OFF;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NCH; i++) duty_q[i] <= DUTY_OFF;
            critical_temp_signal <= 1'b0;
        end else if (clk_en) begin
            for (int i = 0; i < NCH; i++) duty_q[i] <= duty_d[i];
            critical_temp_signal <= any_ovr_d;
        end
    end

    assign fan_drive_1 = duty_q[0];
    assign fan_drive_2 = duty_q[1];
    assign fan_drive_3 = duty_q[2];

    logic all_full;
    assign all_full = (fan_drive_1 == DUTY_FULL) && (fan_drive_2 == DUTY_FULL) && (fan_drive_3 == DUTY_FULL);

    // per-channel checks; they watch the temperature and duty inputs as well as state that this block registers
    for (genvar g = 0; g < NCH; g++) begin : g_chk
        property p_ovr_full;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && temp_a[g] > crit_q[g]) |=> (all_full && critical_temp_signal);
        endproperty
        a_ovr_full: assert property (p_ovr_full) else $error("override did not force full duty");

        property p_ovr_hold;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && ovr_q[g] && temp_a[g] >= crit_off[g]) |=> (ovr_q[g] && all_full);
        endproperty
        a_ovr_hold: assert property (p_ovr_hold) else $error("override released above release point");

        property p_ovr_release;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && temp_a[g] < crit_off[g]) |=> !ovr_q[g];
        endproperty
        a_ovr_release: assert property (p_ovr_release) else $error("override not released below point");

        property p_zero_margin;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && margin_q[g] == 4'h0 && temp_a[g] < crit_q[g]) |=> !ovr_q[g];
        endproperty
        a_zero_margin: assert property (p_zero_margin) else $error("zero margin still holds override");

        property p_run_hold;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && run_q[g] && temp_a[g] >= run_off[g]) |=> run_q[g];
        endproperty
        a_run_hold: assert property (p_run_hold) else $error("fan stopped above turn-off point");

        property p_off;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && !any_ovr_d && !floor_sel_q[g] && temp_a[g] < run_off[g]) |=> duty_q[g] == DUTY_OFF;
        endproperty
        a_off: assert property (p_off) else $error("output not off below turn-off point");

        property p_floor;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && !any_ovr_d && floor_sel_q[g] && temp_a[g] <= start_q[g]) |=> duty_q[g] == $past(min_q[g]);
        endproperty
        a_floor: assert property (p_floor) else $error("always-running output left its floor");

        property p_cap;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && !any_ovr_d && !floor_sel_q[g]) |=> duty_q[g] <= $past(max_q[g]);
        endproperty
        a_cap: assert property (p_cap) else $error("duty exceeded ceiling below critical");

        property p_crit_rst;
            @(posedge core_clk) disable iff (!resetn)
            ($past(resetn) == 1'b0) |-> (crit_q[g] == CRIT_RST && margin_q[g] == MARGIN_RST);
        endproperty
        a_crit_rst: assert property (p_crit_rst) else $error("limit or margin reset value wrong");

        property p_ovr_flag;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && temp_a[g] > crit_q[g]) |=> ovr_q[g];
        endproperty
        a_ovr_flag: assert property (p_ovr_flag) else $error("channel override flag not set");

        property p_run_set;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && temp_a[g] > start_q[g]) |=> run_q[g];
        endproperty
        a_run_set: assert property (p_run_set) else $error("fan not started above fan-start");

        property p_run_clear;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && temp_a[g] < run_off[g]) |=> !run_q[g];
        endproperty
        a_run_clear: assert property (p_run_clear) else $error("fan ran below turn-off point");

        property p_follow;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && !any_ovr_d && temp_a[g] > start_q[g] && auto_a[g] <= max_q[g])
                |=> (duty_q[g] == $past(auto_a[g]));
        endproperty
        a_follow: assert property (p_follow) else $error("output did not follow automatic duty");

        property p_ceiling;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && !any_ovr_d && temp_a[g] > start_q[g] && auto_a[g] > max_q[g])
                |=> (duty_q[g] == $past(max_q[g]));
        endproperty
        a_ceiling: assert property (p_ceiling) else $error("duty not held at ceiling");

        property p_crit_write;
            @(posedge core_clk) disable iff (!resetn)
            (clk_en && wr && idx == REG_CRIT_R1 + 8'(g)) |=> (crit_q[g] == $past(pwdata[7:0]));
        endproperty
        a_crit_write: assert property (p_crit_write) else $error("critical limit write lost");

        // the enable must gate every update, flags included, or a frozen block drifts
        property p_freeze;
            @(posedge core_clk) disable iff (!resetn)
            !clk_en |=> ($stable(duty_q[g]) && $stable(ovr_q[g]) && $stable(run_q[g]) && $stable(crit_q[g]));
        endproperty
        a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
    end

    property p_or_all;
        @(posedge core_clk) disable iff (!resetn)
        (|ovr_q) |-> (all_full && critical_temp_signal);
    endproperty
    a_or_all: assert property (p_or_all) else $error("single channel override not on all outputs");

    property p_unmapped;
        @(posedge core_clk) disable iff (!resetn)
        (psel && penable && pready && !hit) |-> (pslverr && prdata == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

    property p_no_ovr_quiet;
        @(posedge core_clk) disable iff (!resetn)
        !(|ovr_q) |-> !critical_temp_signal;
    endproperty
    a_no_ovr_quiet: assert property (p_no_ovr_quiet) else $error("critical signal without override");

    property p_margin_a_write;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && wr && idx == REG_MARGIN_A) |=> ({margin_q[0], margin_q[1]} == $past(pwdata[7:0]));
    endproperty
    a_margin_a_write: assert property (p_margin_a_write) else $error("margin a write lost");

    property p_margin_b_write;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && wr && idx == REG_MARGIN_B) |=> (margin_q[2] == $past(pwdata[MARGIN_HI_LSB +: 4]));
    endproperty
    a_margin_b_write: assert property (p_margin_b_write) else $error("margin b write lost");

    property p_floor_write;
        @(posedge core_clk) disable iff (!resetn)
        (clk_en && wr && idx == REG_FLOOR_SEL) |=> (floor_sel_q == $past(pwdata[FLOOR_SEL_LSB +: 3]));
    endproperty
    a_floor_write: assert property (p_floor_write) else $error("floor select write lost");

endmodule

// File: hdl/fco_pkg.sv
// constants for the critical-limit override and off-margin block
// assumes an apb master on the register side and byte-wide temperature codes
package fco_pkg;

    localparam int unsigned NCH = 3;

    // register indices; byte address is four times the index
    localparam logic [7:0] REG_FLOOR_SEL = 8'h62;
    localparam logic [7:0] REG_CRIT_R1   = 8'h6A;
    localparam logic [7:0] REG_CRIT_LOC  = 8'h6B;
    localparam logic [7:0] REG_CRIT_R2   = 8'h6C;
    localparam logic [7:0] REG_MARGIN_A  = 8'h6D;
    localparam logic [7:0] REG_MARGIN_B  = 8'h6E;
    localparam logic [7:0] REG_START_R1  = 8'h70;
    localparam logic [7:0] REG_MIN_1     = 8'h73;
    localparam logic [7:0] REG_MAX_1     = 8'h76;
    localparam logic [7:0] REG_STATUS    = 8'h79;

    localparam int unsigned MARGIN_HI_LSB = 4;
    localparam int unsigned MARGIN_LO_LSB = 0;
    localparam int unsigned FLOOR_SEL_LSB = 5;
    localparam int unsigned STATUS_RUN_LSB = 4;

    localparam logic [7:0] CRIT_RST      = 8'hA4;
    localparam logic [3:0] MARGIN_RST    = 4'h4;
    localparam logic [2:0] FLOOR_SEL_RST = 3'h0;
    localparam logic [7:0] START_RST     = 8'h5A;
    localparam logic [7:0] MIN_RST       = 8'h40;
    localparam logic [7:0] MAX_RST       = 8'hFF;
    localparam logic [7:0] DUTY_FULL     = 8'hFF;
    localparam logic [7:0] DUTY_OFF      = 8'h00;

endpackage

// File: tb/fco_fan_model.sv
// fan side model: watches the three fan drive duties
// assumes duties are registered on core_clk
`timescale 1ns/1ns
module fco_fan_model
    import fco_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  fan_drive_1,
    input  wire logic [7:0]  fan_drive_2,
    input  wire logic [7:0]  fan_drive_3,
    output logic      [15:0] full_cycles
);
    // counts cycles with every fan spinning flat out, as seen during a critical event
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            full_cycles <= 16'h0000;
        end else if (fan_drive_1 == DUTY_FULL && fan_drive_2 == DUTY_FULL && fan_drive_3 == DUTY_FULL) begin
            full_cycles <= full_cycles + 16'h0001;
        end
    end
endmodule

// File: tb/tb_fan_critical_override_hyst.sv
// testbench for the critical override and off-margin block
// assumes zero wait state apb and one cycle from temperature to fan duty
`timescale 1ns/1ns
module tb_fan_critical_override_hyst;
    import fco_pkg::*;
    logic        core_clk, resetn, clk_en, psel, penable, pwrite, pready, pslverr, crit, err;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  t [3];
    logic [7:0]  a [3];
    logic [7:0]  run [3];
    logic [7:0]  d1, d2, d3;
    logic [15:0] full_cycles;
    int          bad_count, cmp_count;

    fco_override u_fco_override (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .temp_remote1(t[0]), .temp_local(t[1]), .temp_remote2(t[2]),
        .auto_duty_1(a[0]), .auto_duty_2(a[1]), .auto_duty_3(a[2]), .fan_drive_1(d1), .fan_drive_2(d2),
        .fan_drive_3(d3), .critical_temp_signal(crit));
    fco_fan_model u_fco_fan_model (.core_clk(core_clk), .resetn(resetn), .fan_drive_1(d1),
        .fan_drive_2(d2), .fan_drive_3(d3), .full_cycles(full_cycles));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits on pready but gives up after a bounded count
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task set_temp(input int ch, input logic [7:0] v);
        @(posedge core_clk);
        t[ch] <= v;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    function automatic logic [7:0] drive(input int ch);
        return (ch == 0) ? d1 : (ch == 1) ? d2 : d3;
    endfunction

    // raise one channel over its limit, then walk it down through the margin
    task hyst(input int ch, input logic [7:0] m);
        set_temp(ch, 8'hA5);
        chk(32'(crit), 32'h1);
        chk(32'({d1, d2, d3}), 32'hFFFFFF);
        apb(1'b0, REG_STATUS, 8'h00);
        chk(rd, 32'h11 << ch);
        set_temp(ch, 8'hA4 - m);
        chk(32'(crit), 32'h1);
        set_temp(ch, 8'hA3 - m);
        chk(32'(crit), 32'h0);
        chk(32'(drive(ch)), 32'(run[ch]));
        set_temp(ch, 8'h30);
    endtask

    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h00000000;
        // normal temperatures sit far below the fail-safe limits
        t = '{8'h30, 8'h30, 8'h30};
        a = '{8'h10, 8'h20, 8'h30};
        run = '{8'h08, 8'h20, 8'h30};
        bad_count = 0;
        cmp_count = 0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, REG_CRIT_R1 + 8'(i), 8'h00);
            chk(rd, 32'(CRIT_RST));
        end
        apb(1'b0, REG_MARGIN_A, 8'h00);
        chk(rd, {24'h0, MARGIN_RST, MARGIN_RST});
        chk({31'h0, err}, 32'h0);
        apb(1'b0, REG_MARGIN_B, 8'h00);
        chk(rd, {24'h0, MARGIN_RST, 4'h0});
        apb(1'b0, REG_FLOOR_SEL, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test reset values done");
        // a low ceiling on output 1 must not survive the override
        apb(1'b1, REG_MAX_1, 8'h08);
        for (int i = 0; i < 3; i++) hyst(i, 8'h04);
        $display("test default margins done");
        apb(1'b1, REG_MARGIN_A, 8'h0F);
        apb(1'b1, REG_MARGIN_B, 8'h1F);
        apb(1'b0, REG_MARGIN_B, 8'h00);
        chk(rd, 32'h10);
        hyst(0, 8'h00);
        hyst(1, 8'h0F);
        hyst(2, 8'h01);
        // zero margin was only for the test; software keeps a real gap
        apb(1'b1, REG_MARGIN_A, 8'h4F);
        apb(1'b0, REG_MARGIN_A, 8'h00);
        chk(rd, 32'h4F);
        $display("test programmed margins done");
        set_temp(2, 8'h5B);
        chk(32'(d3), 32'h30);
        set_temp(2, 8'h59);
        chk(32'(d3), 32'h30);
        set_temp(2, 8'h58);
        chk(32'(d3), 32'(DUTY_OFF));
        apb(1'b1, REG_FLOOR_SEL, 8'h80);
        set_temp(2, 8'h57);
        chk(32'(d3), 32'(MIN_RST));
        set_temp(2, 8'h5B);
        chk(32'(d3), 32'h30);
        set_temp(2, 8'h59);
        chk(32'(d3), 32'(MIN_RST));
        apb(1'b1, REG_FLOOR_SEL, 8'hFF);
        apb(1'b0, REG_FLOOR_SEL, 8'h00);
        chk(rd, 32'hE0);
        chk(32'(d1), 32'(MIN_RST));
        $display("test fan floor done");
        // a frozen clock enable must hold the override back
        @(posedge core_clk);
        clk_en <= 1'b0;
        set_temp(0, 8'hA5);
        chk(32'(crit), 32'h0);
        chk(32'(d1), 32'(MIN_RST));
        @(posedge core_clk);
        clk_en <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk(32'(crit), 32'h1);
        set_temp(0, 8'h30);
        chk({31'h0, full_cycles != 16'h0000}, 32'h1);
        $display("test clock enable done");
        // a reset in mid-run must bring back the limit and the floor defaults
        apb(1'b1, REG_CRIT_R1, 8'h80);
        apb(1'b0, REG_CRIT_R1, 8'h00);
        chk(rd, 32'h80);
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        apb(1'b0, REG_CRIT_R1, 8'h00);
        chk(rd, 32'(CRIT_RST));
        apb(1'b0, REG_FLOOR_SEL, 8'h00);
        chk(rd, 32'h0);
        chk(32'(d1), 32'(DUTY_OFF));
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
